// *** inc/phyei_pkg.sv ***
// Constants and types shared by the event interrupt unit and its management slave
package phyei_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the management interface
  // ----------------------------------------------------------------
  localparam logic [4:0] PHYEI_REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] PHYEI_REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] PHYEI_REG_MODE_CTRL    = 5'h11;
  localparam logic [4:0] PHYEI_REG_SRC_FLAGS    = 5'h1d;
  localparam logic [4:0] PHYEI_REG_EN_MASK      = 5'h1e;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PHYEI_BIT_ENERGY      = 7;
  localparam int PHYEI_BIT_AN_DONE     = 6;
  localparam int PHYEI_BIT_REM_FAULT   = 5;
  localparam int PHYEI_BIT_LINK_DOWN   = 4;
  localparam int PHYEI_BIT_LP_ACK      = 3;
  localparam int PHYEI_BIT_PD_FAULT    = 2;
  localparam int PHYEI_BIT_PAGE_RX     = 1;
  localparam int PHYEI_MODE_ALT_BIT    = 6;
  localparam int PHYEI_MODE_ENERGY_BIT = 1;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:1] PHYEI_FLAG_RST  = 7'h40;
  localparam logic [7:1] PHYEI_MASK_RST  = 7'h00;
  localparam logic       PHYEI_ALT_RST   = 1'b0;
  localparam logic [7:1] PHYEI_PREV_RST  = 7'h40;

  // ----------------------------------------------------------------
  // Management frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] PHYEI_PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] PHYEI_HDR_LAST     = 6'h0b;
  localparam logic [5:0] PHYEI_DATA_LAST    = 6'h0f;
  localparam logic [1:0] PHYEI_OP_READ      = 2'h2;
  localparam logic [1:0] PHYEI_OP_WRITE     = 2'h1;

  // ----------------------------------------------------------------
  // Energy detect late pulse timing
  // ----------------------------------------------------------------
  localparam int PHYEI_CLK_HZ         = 40000000;
  localparam int PHYEI_LATE_DELAY_MS  = 1000;
  localparam int PHYEI_LATE_PULSE_MS  = 256;
  localparam int PHYEI_LATE_DELAY_CYC = PHYEI_LATE_DELAY_MS * (PHYEI_CLK_HZ / 1000);
  localparam int PHYEI_LATE_PULSE_CYC = PHYEI_LATE_PULSE_MS * (PHYEI_CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SMI_IDLE  = 3'h0,
    SMI_START = 3'h1,
    SMI_HDR   = 3'h3,
    SMI_TURN  = 3'h2,
    SMI_DATA  = 3'h6
  } phyei_smi_state_type;

  typedef enum logic [1:0] {
    LATE_IDLE  = 2'h0,
    LATE_ARMED = 2'h1,
    LATE_WAIT  = 2'h3,
    LATE_PULSE = 2'h2
  } phyei_late_state_type;

endpackage

// *** inc/phyei_smi_if.sv ***
// Register access carrier between the management slave and the interrupt unit
`timescale 1ns/1ps
interface phyei_smi_if;
  logic        rd_stb;
  logic        wr_stb;
  logic [4:0]  addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  modport smi  (output rd_stb, output wr_stb, output addr, output wr_data, input rd_data);
  modport regs (input rd_stb, input wr_stb, input addr, input wr_data, output rd_data);
endinterface

// *** logic/phyei_smi_slave.sv ***
// Serial management slave: frame decode, register strobes and read shifting
`timescale 1ns/1ps
module phyei_smi_slave
  import phyei_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // Management pins
  input  wire logic       mdc_in,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_out,
  // Own address
  input  wire logic [4:0] phy_addr_in,
  // Register side
  phyei_smi_if.smi        bus
);

  logic                mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
  phyei_smi_state_type st_q, st_d;
  logic [5:0]          cnt_q, cnt_d;
  logic [15:0]         sh_q, sh_d;
  logic [4:0]          addr_q, addr_d;
  logic                rd_q, rd_d, wr_q, wr_d;
  logic                rstb_q, rstb_d, wstb_q, wstb_d;
  logic                out_q, out_d, oe_q, oe_d;
  logic                rise, bit_in;
  logic [11:0]         hdr;

  // Pin synchronisers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mdc_s1_q  <= 1'b0;
      mdc_s2_q  <= 1'b0;
      mdc_s3_q  <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q  <= mdc_in;
      mdc_s2_q  <= mdc_s1_q;
      mdc_s3_q  <= mdc_s2_q;
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  assign rise   = mdc_s2_q & ~mdc_s3_q;
  assign bit_in = mdio_s2_q;
  assign hdr    = {sh_q[10:0], bit_in};

  // Frame sequencing on each management clock rising edge
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; addr_d = addr_q;
    rd_d = rd_q; wr_d = wr_q; out_d = out_q; oe_d = oe_q;
    rstb_d = 1'b0;
    wstb_d = 1'b0;
    if (rstb_q) sh_d = bus.rd_data;             // Snapshot before read side effects
    if (rise) begin
      unique case (st_q)
        SMI_IDLE: begin
          if (bit_in) begin
            if (cnt_q != PHYEI_PREAMBLE_LEN) cnt_d = cnt_q + 6'h01;
          end else begin
            st_d  = (cnt_q == PHYEI_PREAMBLE_LEN) ? SMI_START : SMI_IDLE;
            cnt_d = 6'h00;
          end
        end
        SMI_START: begin
          st_d  = bit_in ? SMI_HDR : SMI_IDLE;
          cnt_d = 6'h00;
        end
        SMI_HDR: begin
          sh_d  = {sh_q[14:0], bit_in};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == PHYEI_HDR_LAST) begin
            st_d   = SMI_TURN;
            cnt_d  = 6'h00;
            addr_d = hdr[4:0];
            rd_d   = (hdr[11:10] == PHYEI_OP_READ) && (hdr[9:5] == phy_addr_in);
            wr_d   = (hdr[11:10] == PHYEI_OP_WRITE) && (hdr[9:5] == phy_addr_in);
            rstb_d = (hdr[11:10] == PHYEI_OP_READ) && (hdr[9:5] == phy_addr_in);
          end
        end
        SMI_TURN: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h00) begin
            oe_d  = rd_q;
            out_d = 1'b0;
          end else begin
            st_d  = SMI_DATA;
            cnt_d = 6'h00;
            out_d = sh_q[15];
            sh_d  = {sh_q[14:0], 1'b0};
          end
        end
        SMI_DATA: begin
          cnt_d = cnt_q + 6'h01;
          if (rd_q) begin
            out_d = sh_q[15];
            sh_d  = {sh_q[14:0], 1'b0};
          end else begin
            sh_d  = {sh_q[14:0], bit_in};
          end
          if (cnt_q == PHYEI_DATA_LAST) begin
            st_d   = SMI_IDLE;
            cnt_d  = 6'h00;
            oe_d   = 1'b0;
            wstb_d = wr_q;
          end
        end
        default: begin
          st_d  = SMI_IDLE;
          cnt_d = 6'h00;
          oe_d  = 1'b0;
        end
      endcase
    end
  end

  // Frame state registers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q   <= SMI_IDLE;
      cnt_q  <= 6'h00;
      sh_q   <= 16'h0000;
      addr_q <= 5'h00;
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      rstb_q <= 1'b0;
      wstb_q <= 1'b0;
      out_q  <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      rstb_q <= rstb_d;
      wstb_q <= wstb_d;
      out_q  <= out_d;
      oe_q   <= oe_d;
    end
  end

  // Outputs
  assign bus.rd_stb  = rstb_q;
  assign bus.wr_stb  = wstb_q;
  assign bus.addr    = addr_q;
  assign bus.wr_data = sh_q;
  assign mdio_out    = out_q;
  assign mdio_oe_out = oe_q;

endmodule

// *** logic/phyei_event_irq.sv ***
// Event interrupt unit: source flags, mask, two release modes, energy late pulse
//
// Behaviour
// - Active-low interrupt output asserts whenever an enabled source event occurs.
// - Two modes; both assert on masked source event, differ only in release.
// - Primary mode after reset; primary whenever the alternate select bit is zero.
// - Mask bits in register 30 match flag bits in register 29, bits 7..1.
// - Assert on rising energy, AN done, fault, ack, pd fault, page; falling link.
// - Primary mode: assert on enabled event, release on that source's release event.
// - Primary mode: falling source releases, except link down; reading register 29 releases all.
// - Primary mode: reading register 1 releases link down and remote fault.
// - Primary mode: register 6 read, AN restart or link down release pd fault, page.
// - Alternate mode: clearing the mask bit releases the output immediately.
// - Alternate mode: write one to flag checks source low, or link high.
// - Check true: flag clears and output releases together.
// - Check false: flag stays one and output stays asserted.
// - Energy released while high: 256 ms pulse about one second after energy falls.
// - Energy status presets to one, so flag bit 7 reads one after reset.
// - Mask bit 7 enables energy interrupt; asserts when cable energy appears.
`timescale 1ns/1ps
module phyei_event_irq
  import phyei_pkg::*;
#(
  parameter int unsigned LATE_DELAY_CYCLES = PHYEI_LATE_DELAY_CYC,
  parameter int unsigned LATE_PULSE_CYCLES = PHYEI_LATE_PULSE_CYC
)
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Serial management pins
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_out,
  input  wire logic [4:0]  phy_addr_in,
  // Status sources from the transceiver core
  input  wire logic        energy_detect_in,
  input  wire logic        an_complete_in,
  input  wire logic        remote_fault_in,
  input  wire logic        link_status_in,
  input  wire logic        lp_ack_in,
  input  wire logic        pd_fault_in,
  input  wire logic        page_rcvd_in,
  input  wire logic        an_restart_in,
  // Other registers of the transceiver
  input  wire logic [15:0] ext_rd_data_in,
  output logic [4:0]       ext_addr_out,
  // Interrupt and mode
  output logic             irq_out_n,
  output logic             alt_irq_mode_sel_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  phyei_smi_if reg_bus ();

  logic [7:1]           src_now;
  logic [7:1]           src_prev_q, src_prev_d;
  logic [7:1]           src_rise, src_fall;
  logic [7:1]           flag_q, flag_d;
  logic [7:1]           mask_q, mask_d;
  logic                 alt_q, alt_d;
  logic                 irq_q, irq_d;
  logic [7:1]           clr_vec;
  logic                 rd_flags, rd_basic, rd_anexp;
  logic                 wr_flags, wr_mask, wr_mode;
  logic                 link_down_evt;
  phyei_late_state_type late_q, late_d;
  logic [25:0]          late_cnt_q, late_cnt_d;
  logic                 late_pulse;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Register decode used by read and write strobes
  function automatic logic hit(input logic stb, input logic [4:0] a, input logic [4:0] off);
    hit = stb && (a == off);
  endfunction

  // Zero-extend a seven bit field into a register word
  function automatic logic [15:0] word7(input logic [7:1] v);
    word7 = {8'h00, v, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Management slave
  // ----------------------------------------------------------------
  phyei_smi_slave u_smi (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .mdc_in      (mdc_in),
    .mdio_in     (mdio_in),
    .mdio_out    (mdio_out),
    .mdio_oe_out (mdio_oe_out),
    .phy_addr_in (phy_addr_in),
    .bus         (reg_bus.smi)
  );

  // Access strobes per register
  assign rd_flags = hit(reg_bus.rd_stb, reg_bus.addr, PHYEI_REG_SRC_FLAGS);
  assign rd_basic = hit(reg_bus.rd_stb, reg_bus.addr, PHYEI_REG_BASIC_STATUS);
  assign rd_anexp = hit(reg_bus.rd_stb, reg_bus.addr, PHYEI_REG_AN_EXPANSION);
  assign wr_flags = hit(reg_bus.wr_stb, reg_bus.addr, PHYEI_REG_SRC_FLAGS);
  assign wr_mask  = hit(reg_bus.wr_stb, reg_bus.addr, PHYEI_REG_EN_MASK);
  assign wr_mode  = hit(reg_bus.wr_stb, reg_bus.addr, PHYEI_REG_MODE_CTRL);

  // ----------------------------------------------------------------
  // Source vector and edge detection
  // ----------------------------------------------------------------

  // Active-high source per flag position; link down is inverted link status
  always_comb begin
    src_now                     = '0;
    src_now[PHYEI_BIT_ENERGY]    = energy_detect_in;
    src_now[PHYEI_BIT_AN_DONE]   = an_complete_in;
    src_now[PHYEI_BIT_REM_FAULT] = remote_fault_in;
    src_now[PHYEI_BIT_LINK_DOWN] = ~link_status_in;
    src_now[PHYEI_BIT_LP_ACK]    = lp_ack_in;
    src_now[PHYEI_BIT_PD_FAULT]  = pd_fault_in;
    src_now[PHYEI_BIT_PAGE_RX]   = page_rcvd_in;
  end

  // Rising of the vector is every assertion event
  assign src_prev_d    = src_now;
  assign src_rise      = src_now & ~src_prev_q;
  assign src_fall      = ~src_now & src_prev_q;
  assign link_down_evt = src_rise[PHYEI_BIT_LINK_DOWN];

  // ----------------------------------------------------------------
  // Source flags
  // ----------------------------------------------------------------

  // Release terms, chosen by mode
  always_comb begin
    clr_vec = '0;
    if (!alt_q) begin
      // Primary: falling source, except link down
      clr_vec = src_fall;
      clr_vec[PHYEI_BIT_LINK_DOWN] = 1'b0;
      if (rd_flags) clr_vec = '1;
      if (rd_basic) begin
        clr_vec[PHYEI_BIT_LINK_DOWN] = 1'b1;
        clr_vec[PHYEI_BIT_REM_FAULT] = 1'b1;
      end
      if (rd_anexp || an_restart_in || link_down_evt) begin
        clr_vec[PHYEI_BIT_PD_FAULT] = 1'b1;
        clr_vec[PHYEI_BIT_PAGE_RX]  = 1'b1;
      end
    end else if (wr_flags) begin
      // Alternate: write one checks the source; false keeps the flag
      clr_vec = reg_bus.wr_data[7:1] & ~src_now;
    end
  end

  // Flag update; a new event wins over a release in the same cycle
  always_comb begin
    flag_d = (flag_q & ~clr_vec) | src_rise;
  end

  // ----------------------------------------------------------------
  // Mask and mode registers
  // ----------------------------------------------------------------

  // Software writes; reserved bits are not stored
  always_comb begin
    mask_d = mask_q;
    alt_d  = alt_q;
    if (wr_mask) mask_d = reg_bus.wr_data[7:1];
    if (wr_mode) alt_d = reg_bus.wr_data[PHYEI_MODE_ALT_BIT];
  end

  // ----------------------------------------------------------------
  // Energy detect late pulse
  // ----------------------------------------------------------------

  // Armed when the energy flag was released with energy still present
  always_comb begin
    late_d     = late_q;
    late_cnt_d = late_cnt_q;
    unique case (late_q)
      LATE_IDLE: begin
        if (mask_q[PHYEI_BIT_ENERGY] && flag_q[PHYEI_BIT_ENERGY] &&
            !flag_d[PHYEI_BIT_ENERGY] && src_now[PHYEI_BIT_ENERGY]) begin
          late_d = LATE_ARMED;
        end
      end
      LATE_ARMED: begin
        if (!mask_q[PHYEI_BIT_ENERGY]) begin
          late_d = LATE_IDLE;
        end else if (src_fall[PHYEI_BIT_ENERGY]) begin
          late_d     = LATE_WAIT;
          late_cnt_d = 26'h0000000;
        end
      end
      LATE_WAIT: begin
        late_cnt_d = late_cnt_q + 26'h0000001;
        if (!mask_q[PHYEI_BIT_ENERGY] || src_now[PHYEI_BIT_ENERGY]) begin
          late_d = LATE_IDLE;
        end else if (late_cnt_q == 26'(LATE_DELAY_CYCLES - 1)) begin
          late_d     = LATE_PULSE;
          late_cnt_d = 26'h0000000;
        end
      end
      LATE_PULSE: begin
        late_cnt_d = late_cnt_q + 26'h0000001;
        if (!mask_q[PHYEI_BIT_ENERGY] || late_cnt_q == 26'(LATE_PULSE_CYCLES - 1)) begin
          late_d     = LATE_IDLE;
          late_cnt_d = 26'h0000000;
        end
      end
    endcase
  end

  assign late_pulse = (late_q == LATE_PULSE);

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------

  // Any pending flag that is enabled holds the line low
  always_comb begin
    irq_d = (|(flag_d & mask_d)) | late_pulse;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------

  // Energy status presumed present after reset, flag bit 7 set
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      src_prev_q <= PHYEI_PREV_RST;
      flag_q     <= PHYEI_FLAG_RST;
      mask_q     <= PHYEI_MASK_RST;
      alt_q      <= PHYEI_ALT_RST;
      irq_q      <= 1'b0;
      late_q     <= LATE_IDLE;
      late_cnt_q <= 26'h0000000;
    end else begin
      src_prev_q <= src_prev_d;
      flag_q     <= flag_d;
      mask_q     <= mask_d;
      alt_q      <= alt_d;
      irq_q      <= irq_d;
      late_q     <= late_d;
      late_cnt_q <= late_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------

  // Readback of owned registers, others from the core
  always_comb begin
    unique case (reg_bus.addr)
      PHYEI_REG_SRC_FLAGS: reg_bus.rd_data = word7(flag_q);
      PHYEI_REG_EN_MASK:   reg_bus.rd_data = word7(mask_q);
      PHYEI_REG_MODE_CTRL: begin
        reg_bus.rd_data = 16'h0000;
        reg_bus.rd_data[PHYEI_MODE_ALT_BIT]    = alt_q;
        reg_bus.rd_data[PHYEI_MODE_ENERGY_BIT] = energy_detect_in;
      end
      default:             reg_bus.rd_data = ext_rd_data_in;
    endcase
  end

  assign irq_out_n            = ~irq_q;
  assign alt_irq_mode_sel_out = alt_q;
  assign ext_addr_out         = reg_bus.addr;

endmodule

// *** verification/phyei_irq_properties.sv ***
// Port-level checker for the event interrupt unit, with its bind
`timescale 1ns/1ps
module phyei_irq_checker #(
  parameter int unsigned LATE_PULSE_CYCLES = 8
) (
  // Clock and reset
  input logic sys_clk_in,
  input logic reset_in,
  // Management pins
  input logic mdc_in,
  input logic mdio_out,
  input logic mdio_oe_out,
  // Status sources
  input logic energy_detect_in,
  input logic an_complete_in,
  input logic remote_fault_in,
  input logic link_status_in,
  input logic lp_ack_in,
  input logic pd_fault_in,
  input logic page_rcvd_in,
  input logic an_restart_in,
  // Interrupt and mode
  input logic irq_out_n,
  input logic alt_irq_mode_sel_out
);
  logic [7:1]  src_now;
  logic [7:1]  src_q;
  logic [31:0] low_q, low_d;
  logic        rise_any, fall_any;
  // Source levels, edges, low span length
  always_comb begin
    src_now  = {energy_detect_in, an_complete_in, remote_fault_in, ~link_status_in,
                lp_ack_in, pd_fault_in, page_rcvd_in};
    rise_any = |(src_now & ~src_q);
    fall_any = |(~src_now & src_q);
    low_d    = irq_out_n ? 32'h0 : low_q + 32'h1;
  end
  // Previous levels and low span counter
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      src_q <= 7'h40;
      low_q <= 32'h0;
    end else begin
      src_q <= src_now;
      low_q <= low_d;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  property p_reset_quiet; $fell(reset_in) |-> irq_out_n && !alt_irq_mode_sel_out && !mdio_oe_out; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
  property p_oe_start; $rose(mdio_oe_out) |-> mdc_in && !mdio_out; endproperty
  a_oe_start: assert property (p_oe_start) else $error("read drive started badly");
  property p_oe_hold; $rose(mdio_oe_out) |=> mdio_oe_out [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("read drive dropped early");
  property p_data_step; mdio_oe_out && $changed(mdio_out) |-> mdc_in; endproperty
  a_data_step: assert property (p_data_step) else $error("data moved off clock high");
  property p_alt_write; $changed(alt_irq_mode_sel_out) |-> mdc_in; endproperty
  a_alt_write: assert property (p_alt_write) else $error("mode changed outside a frame");
  property p_irq_set; $fell(irq_out_n) |-> mdc_in || $past(rise_any) || $past(rise_any, 2) || !energy_detect_in;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt without cause");
  property p_irq_clr;
    $rose(irq_out_n) |-> mdc_in || $past(fall_any) || $past(fall_any, 2) || $past(rise_any) || $past(rise_any, 2)
      || $past(an_restart_in) || $past(an_restart_in, 2) || !energy_detect_in;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("release without cause");
  property p_late_len;
    $rose(irq_out_n) && !mdc_in && !energy_detect_in && !$past(fall_any) && !$past(fall_any, 2)
      |-> low_q == LATE_PULSE_CYCLES;
  endproperty
  a_late_len: assert property (p_late_len) else $error("late pulse width wrong");
endmodule

bind phyei_event_irq phyei_irq_checker #(.LATE_PULSE_CYCLES(LATE_PULSE_CYCLES)) u_checker (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .mdc_in(mdc_in), .mdio_out(mdio_out),
  .mdio_oe_out(mdio_oe_out), .energy_detect_in(energy_detect_in), .an_complete_in(an_complete_in),
  .remote_fault_in(remote_fault_in), .link_status_in(link_status_in), .lp_ack_in(lp_ack_in),
  .pd_fault_in(pd_fault_in), .page_rcvd_in(page_rcvd_in), .an_restart_in(an_restart_in),
  .irq_out_n(irq_out_n), .alt_irq_mode_sel_out(alt_irq_mode_sel_out)
);

// *** verification/phyei_smi_host.sv ***
// Management station model driving frames on the clock and data pins
`timescale 1ns/1ps
module phyei_smi_host
  import phyei_pkg::*;
(
  // Clock
  input  wire logic sys_clk_in,
  // Management pins
  input  wire logic mdio_in,
  output logic      mdc_out,
  output logic      mdio_drv_out,
  output logic      mdio_en_out
);
  // Idle: clock still, data released
  initial begin
    mdc_out      = 1'b0;
    mdio_drv_out = 1'b1;
    mdio_en_out  = 1'b0;
  end
  // One bit slot: data while clock low, sample at rise
  task automatic slot(input logic en, input logic val, output logic smp);
    @(posedge sys_clk_in);
    mdc_out      <= 1'b0;
    mdio_en_out  <= en;
    mdio_drv_out <= val;
    repeat (8) @(posedge sys_clk_in);
    mdc_out <= 1'b1;
    smp = mdio_in;
    repeat (7) @(posedge sys_clk_in);
  endtask
  // Frame with preamble; data released on reads
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hffffffff, 2'b01, rd ? PHYEI_OP_READ : PHYEI_OP_WRITE, phy, ra};
    for (int i = 45; i >= 0; i--) slot(1'b1, hdr[i], s);
    slot(!rd, 1'b1, s);
    slot(!rd, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      slot(!rd, wd[i], s);
      rdat[i] = s;
    end
    @(posedge sys_clk_in);
    mdc_out     <= 1'b0;
    mdio_en_out <= 1'b0;
  endtask
endmodule

// *** verification/tb_phyei_event_irq.sv ***
// Self-checking bench for the event interrupt unit
`timescale 1ns/1ps
module tb_phyei_event_irq
  import phyei_pkg::*;
;
  localparam logic [4:0] PHY = 5'h05;
  localparam int         DLY = 20;
  localparam int         PLS = 8;
  localparam logic [4:0] RFL = PHYEI_REG_SRC_FLAGS, RMK = PHYEI_REG_EN_MASK, RMD = PHYEI_REG_MODE_CTRL;
  // Bench state
  logic        sys_clk_in = 1'b0;
  logic        reset_in   = 1'b1;
  logic [7:1]  src        = 7'h40;
  logic        an_rst     = 1'b0;
  logic [15:0] ext_rd     = 16'hc3a5;
  logic        mdc, host_drv, host_en, mdio_out, mdio_oe, irq_n, alt;
  logic [4:0]  ext_a;
  wire         mdio_w;
  int          fails      = 0;
  int          checks     = 0;
  int          n;
  // Clock and pulled-up data line
  always #12.5 sys_clk_in = ~sys_clk_in;
  assign mdio_w = mdio_oe ? mdio_out : (host_en ? host_drv : 1'b1);
  // Design and management station
  phyei_event_irq #(.LATE_DELAY_CYCLES(DLY), .LATE_PULSE_CYCLES(PLS)) u_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .mdc_in(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe), .phy_addr_in(PHY), .energy_detect_in(src[7]), .an_complete_in(src[6]),
    .remote_fault_in(src[5]), .link_status_in(~src[4]), .lp_ack_in(src[3]), .pd_fault_in(src[2]),
    .page_rcvd_in(src[1]), .an_restart_in(an_rst), .ext_rd_data_in(ext_rd), .ext_addr_out(ext_a),
    .irq_out_n(irq_n), .alt_irq_mode_sel_out(alt));
  phyei_smi_host u_host (.sys_clk_in(sys_clk_in), .mdio_in(mdio_w), .mdc_out(mdc), .mdio_drv_out(host_drv),
    .mdio_en_out(host_en));
  // Comparison, counted
  task automatic check(input logic [15:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Register access
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.frame(1'b1, PHY, a, 16'h0000, d);
    check(d, exp, "read");
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] d;
    u_host.frame(1'b0, PHY, a, v, d);
    repeat (8) @(posedge sys_clk_in);
  endtask
  task automatic irq(input logic exp);
    repeat (4) @(posedge sys_clk_in);
    check({15'h0, irq_n}, {15'h0, exp}, "irq");
  endtask
  task automatic set_src(input int i, input logic v);
    @(posedge sys_clk_in);
    src[i] <= v;
  endtask
  task automatic done(input string t);
    $display("test %s ended, fails %0d", t, fails);
  endtask
  // Closing verdict
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (80000) @(posedge sys_clk_in);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
  // Test sequence
  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(RFL, 16'h0080);
    rd(RMK, 16'h0000);
    rd(RMD, 16'h0002);
    set_src(6, 1'b1);
    irq(1'b1);
    wr(RMK, 16'hffff);
    rd(RMK, 16'h00fe);
    irq(1'b0);
    wr(RMK, 16'h007e);
    rd(RFL, 16'h0040);
    irq(1'b1);
    set_src(6, 1'b0);
    done("reset and mask");
    for (int i = 1; i <= 6; i++) begin
      set_src(i, 1'b1);
      irq(1'b0);
      if (i == 4) rd(PHYEI_REG_BASIC_STATUS, 16'hc3a5);
      else if (i % 2 == 1) set_src(i, 1'b0);
      else rd(RFL, 16'h0001 << i);
      irq(1'b1);
      set_src(i, 1'b0);
    end
    check({11'h0, ext_a}, 16'h001d, "ext addr");
    for (int k = 0; k < 3; k++) begin
      set_src(2, 1'b1);
      set_src(1, 1'b1);
      irq(1'b0);
      if (k == 0) rd(PHYEI_REG_AN_EXPANSION, 16'hc3a5);
      if (k == 1) begin
        @(posedge sys_clk_in);
        an_rst <= 1'b1;
        @(posedge sys_clk_in);
        an_rst <= 1'b0;
      end
      if (k == 2) set_src(4, 1'b1);
      irq(k == 2 ? 1'b0 : 1'b1);
      rd(RFL, k == 2 ? 16'h0010 : 16'h0000);
      set_src(1, 1'b0);
      set_src(2, 1'b0);
      set_src(4, 1'b0);
    end
    done("primary release");
    wr(RMD, 16'h0040);
    check({15'h0, alt}, 16'h0001, "alt pin");
    rd(RMD, 16'h0042);
    for (int i = 4; i <= 6; i++) begin
      set_src(i, 1'b1);
      irq(1'b0);
      wr(RFL, 16'h0001 << i);
      rd(RFL, 16'h0001 << i);
      set_src(i, 1'b0);
      irq(1'b0);
      wr(RFL, 16'h0001 << i);
      rd(RFL, 16'h0000);
      irq(1'b1);
    end
    set_src(5, 1'b1);
    irq(1'b0);
    wr(RMK, 16'h005e);
    irq(1'b1);
    rd(RFL, 16'h0020);
    set_src(5, 1'b0);
    wr(RFL, 16'h0020);
    wr(RMK, 16'h007e);
    irq(1'b1);
    done("alternate release");
    wr(RMD, 16'h0000);
    wr(RMK, 16'h0080);
    set_src(7, 1'b0);
    set_src(7, 1'b1);
    irq(1'b0);
    rd(RFL, 16'h0080);
    irq(1'b1);
    set_src(7, 1'b0);
    n = 0;
    while (irq_n === 1'b1 && n < 60) begin
      @(posedge sys_clk_in);
      n++;
    end
    check({15'h0, n >= DLY && n <= DLY + 4}, 16'h0001, "late delay");
    n = 0;
    while (irq_n === 1'b0 && n < 60) begin
      @(posedge sys_clk_in);
      n++;
    end
    check(n[15:0], 16'(PLS), "late width");
    wr(RMK, 16'h0000);
    done("late energy pulse");
    give_verdict();
  end
endmodule
